// ### yc_sep_map.svh
// Constants for the two-line luma/chroma separator
`ifndef YC_SEP_MAP_SVH
`define YC_SEP_MAP_SVH

// Sample width of the digitised composite signal
`define YC_DATA_W 8
// Samples per horizontal line at four times subcarrier
`define YC_LINE_LEN 910
// Target code for the sync tip after clamping
`define YC_CLAMP_LEVEL 8'h10
// Chroma code that stands for zero colour
`define YC_CHROMA_ZERO 8'h80
// Sample clock is this multiple of the subcarrier reference
`define YC_FSC_MULT 4
// Sample clock period in picoseconds
`define YC_CLK_PERIOD_PS 8000
// Reference period in clock cycles, from the multiple
`define YC_REF_CYCLES (`YC_FSC_MULT)
// Pipeline stages from sample accept to result push
`define YC_PIPE_DEPTH 3'h5
// Entries in the output buffer
`define YC_BUF_DEPTH 2
// Lock requires this many good reference periods
`define YC_LOCK_GOOD 3'h3

`endif

// ### yc_sep_pkg.sv
// Types shared by the separator and its helpers
package yc_sep_pkg;

    // One result pair, luma and chroma
    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
    } yc_pair_s;

    // Reference tracking state of the timing generator
    typedef enum logic [1:0] {
        REF_SEARCH = 2'b00,
        REF_LOCKED = 2'b01,
        REF_LOST   = 2'b10
    } ref_state_e;

endpackage

// ### line_delay_mem.sv
// One-line sample delay memory
`timescale 1ns/10ps
`default_nettype none
module line_delay_mem #(
    parameter int W = 8,
    parameter int DEPTH = 910
) (
    input wire logic core_clk,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] addr,
    input wire logic [W-1:0] wr_data,
    output logic [W-1:0] rd_data
);
    // Storage for one whole line
    logic [W-1:0] mem [0:DEPTH-1];
    // Registered read of the old word
    logic [W-1:0] rd_r;

    // Read before write: the word returned is one line old
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            rd_r <= mem[addr];
            mem[addr] <= wr_data;
        end
    end

    assign rd_data = rd_r;
endmodule // line_delay_mem
`default_nettype wire

// ### yc_out_buf.sv
// Small valid/ready buffer for result words
`timescale 1ns/10ps
`default_nettype none
module yc_out_buf #(
    parameter int W = 16,
    parameter int DEPTH = 2
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // Entry storage
    logic [W-1:0] ent [0:DEPTH-1];
    // Write and read positions
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    // Fill count, one wider than the pointers
    logic [AW:0] cnt_r;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire [AW-1:0] wp_inc = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
    wire [AW-1:0] rp_inc = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;

    // Honest full and empty from the count
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = ent[rp_r];

    // Pointer and count update
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= wp_inc;
            if (pop) rp_r <= rp_inc;
            if (push && !pop) cnt_r <= cnt_r + 1'b1;
            else if (pop && !push) cnt_r <= cnt_r - 1'b1;
        end
    end

    // Entry write, no reset needed on data
    always_ff @(posedge core_clk) begin
        if (push) ent[wp_r] <= in_data;
    end
endmodule // yc_out_buf
`default_nettype wire

// ### two_line_yc_separator.sv
// Two-line comb luma/chroma separator, top level
// Operation
// - Killer high: clamped composite passes to luma unfiltered
// - Killer low: normal luma/chroma separation
// - Clamp feedback drives sync tip to level
// - Composite arrives as 8-bit samples
// - Line memory returns each sample one line later
// - Band-pass centred on subcarrier extracts chroma
// - Comb uses current and delayed line correlation
// - System clock is four times subcarrier reference
// - Timing generator times clock and line memory
// - Two 8-bit outputs: luma and chroma
`timescale 1ns/10ps
`default_nettype none
`include "yc_sep_map.svh"
module two_line_yc_separator #(
    parameter int LINE_LEN = `YC_LINE_LEN,
    parameter int BUF_DEPTH = `YC_BUF_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] composite_video_in,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic subcarrier_reference_in,
    input wire logic color_killer,
    output logic ref_locked,
    output logic out_valid,
    input wire logic out_ready,
    output yc_sep_pkg::yc_pair_s yc_out
);
    import yc_sep_pkg::*;

    // Line position width; LINE_LEN need not be a power of two,
    // the position counter wraps at LINE_LEN - 1 by itself, and a
    // short line length is fine for quick runs.
    localparam int PW = $clog2(LINE_LEN);

    // Buffer has room, so the pipeline may advance
    logic buf_ready;
    // Pipeline advance strobe
    wire adv = sample_valid & buf_ready;

    // ---------------- timing generator ----------------
    // The sample clock arrives already multiplied, so this block cannot
    // make it; it only checks that exactly four clocks fall in each
    // reference period and reports lock. A wrong ratio drops lock for
    // one state before the search starts again. Limitation: a slow
    // drift inside one clock is not seen.
    // Delayed reference for edge detection
    logic ref_d_r;
    // Clocks since the last reference rising edge
    logic [3:0] ref_cnt_r;
    // Good periods seen in a row
    logic [2:0] good_r;
    // Reference tracking state
    ref_state_e ref_st_r;
    ref_state_e ref_st_nxt;
    // Position within the current line
    logic [PW-1:0] pos_r;

    wire ref_rise = subcarrier_reference_in & ~ref_d_r;
    // A period is good when it spans exactly the multiple
    wire ref_good = (ref_cnt_r == 4'(`YC_REF_CYCLES - 1));
    wire ref_long = (ref_cnt_r > 4'(`YC_REF_CYCLES - 1));
    wire line_end = (pos_r == PW'(LINE_LEN - 1));

    always_comb begin
        ref_st_nxt = ref_st_r;
        case (ref_st_r)
            REF_SEARCH: begin
                // Need several clean periods before trusting it
                if (good_r == `YC_LOCK_GOOD) ref_st_nxt = REF_LOCKED;
            end
            REF_LOCKED: begin
                // Wrong period length means the clock ratio is off
                if ((ref_rise && !ref_good) || ref_long) ref_st_nxt = REF_LOST;
            end
            // Lost lasts one cycle so the drop is always seen
            REF_LOST: begin
                ref_st_nxt = REF_SEARCH;
            end
            default: begin
                ref_st_nxt = REF_SEARCH;
            end
        endcase
    end

    // Reference edge counting
    // The count saturates just past the nominal period, which is
    // enough to tell a long period from a good one.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ref_d_r <= 1'b0;
            ref_cnt_r <= 4'h0;
            good_r <= 3'h0;
            ref_st_r <= REF_SEARCH;
        end else begin
            ref_d_r <= subcarrier_reference_in;
            ref_st_r <= ref_st_nxt;
            if (ref_rise) ref_cnt_r <= 4'h0;
            else if (!ref_long) ref_cnt_r <= ref_cnt_r + 4'h1;
            if (ref_rise && ref_good && good_r != `YC_LOCK_GOOD) good_r <= good_r + 3'h1;
            else if ((ref_rise && !ref_good) || ref_long) good_r <= 3'h0;
        end
    end

    // Lock shows the source keeps a steady reference
    assign ref_locked = (ref_st_r == REF_LOCKED);

    // The position also addresses the line memory, so both share
    // one counter and cannot drift apart.
    // Line position drives the memory address
    always_ff @(posedge core_clk) begin
        if (!rst_n) pos_r <= '0;
        else if (adv) pos_r <= line_end ? '0 : pos_r + 1'b1;
    end

    // ---------------- clamp ----------------
    // The offset is a slow loop: it moves one code per line, so a
    // noisy sync tip shifts it by one step at most. The minimum is
    // taken over clamped samples, which closes the feedback loop.
    // Limitation: a line with no sync tip pulls the offset down,
    // and the next tip brings it back one code per line.
    // Offset added to raw samples
    logic signed [9:0] clamp_off_r;
    // Smallest clamped sample seen this line
    logic [7:0] line_min_r;
    // Offset applied, then saturated to the code range
    wire signed [10:0] clamp_sum = $signed({3'b000, composite_video_in}) + 11'(clamp_off_r);
    // Samples stay 8 bits through the path
    wire [7:0] clamped = clamp_sum[10] ? 8'h00 : (|clamp_sum[9:8] ? 8'hff : clamp_sum[7:0]);
    wire [7:0] min_next = (clamped < line_min_r) ? clamped : line_min_r;

    // Once per line nudge offset toward level
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            clamp_off_r <= 10'sh000;
            line_min_r <= 8'hff;
        end else if (adv) begin
            if (line_end) begin
                line_min_r <= 8'hff;
                // One step per line keeps noise from pumping it
                if (min_next > `YC_CLAMP_LEVEL && clamp_off_r != -10'sd255)
                    clamp_off_r <= clamp_off_r - 10'sd1;
                else if (min_next < `YC_CLAMP_LEVEL && clamp_off_r != 10'sd255)
                    clamp_off_r <= clamp_off_r + 10'sd1;
            end else begin
                line_min_r <= min_next;
            end
        end
    end

    // ---------------- line delay ----------------
    // The memory is not reset, so the first line read back is unknown;
    // chroma is only meaningful once a whole line has passed.
    // Sample one line old
    logic [7:0] old_smp;
    // Current sample, aligned with the memory read
    logic [7:0] cur_r;

    line_delay_mem #(
        .W(8),
        .DEPTH(LINE_LEN)
    ) u_line (
        .core_clk(core_clk),
        .wr_en(adv),
        .addr(pos_r),
        .wr_data(clamped),
        .rd_data(old_smp)
    );

    // Current sample, registered to line up with the memory read
    always_ff @(posedge core_clk) begin
        if (adv) cur_r <= clamped;
    end

    // ---------------- band-pass taps ----------------
    // Taps move on the advance strobe only, so stalls never smear
    // the filter; tap k holds the sample k accepts older.
    // Tap lines for current and delayed line, tap 0 newest
    logic [7:0] tc_r [0:4];
    logic [7:0] td_r [0:4];

    assign tc_r[0] = cur_r;
    assign td_r[0] = old_smp;

    // Four-tap shift per line path
    genvar gi;
    generate
        for (gi = 1; gi < 5; gi++) begin : g_tap
            always_ff @(posedge core_clk) begin
                if (adv) begin
                    tc_r[gi] <= tc_r[gi-1];
                    td_r[gi] <= td_r[gi-1];
                end
            end
        end
    endgenerate

    // At 4x rate, (-1,0,2,0,-1)/4 peaks at subcarrier
    wire signed [10:0] bp_cur = (11'($signed({3'b000, tc_r[2]})) <<< 1)
                              - $signed({3'b000, tc_r[0]}) - $signed({3'b000, tc_r[4]});
    wire signed [10:0] bp_old = (11'($signed({3'b000, td_r[2]})) <<< 1)
                              - $signed({3'b000, td_r[0]}) - $signed({3'b000, td_r[4]});
    wire signed [10:0] bpc = bp_cur >>> 2;
    // Subcarrier flips phase each line, so invert the old one
    wire signed [10:0] bpo = -(bp_old >>> 2);

    // ---------------- logical comb ----------------
    // Lines that disagree in sign are not vertically correlated, so
    // the comb drops chroma there rather than risk cross colour. The
    // smaller magnitude of two agreeing lines limits dot crawl at
    // vertical colour edges, at the cost of some chroma resolution.
    wire bpc_neg = bpc[10];
    wire bpo_neg = bpo[10];
    wire [10:0] mag_c = bpc_neg ? 11'(-bpc) : bpc;
    wire [10:0] mag_o = bpo_neg ? 11'(-bpo) : bpo;
    // Agreeing lines: keep smaller, else no chroma
    wire signed [10:0] comb_c = (bpc_neg != bpo_neg) ? 11'sd0 :
                                ((mag_c < mag_o) ? bpc : bpo);

    // Luma from the centre tap minus chroma
    wire signed [10:0] luma_sep = $signed({3'b000, tc_r[2]}) - comb_c;
    wire [7:0] luma_sat = luma_sep[10] ? 8'h00 : (|luma_sep[9:8] ? 8'hff : luma_sep[7:0]);
    // Chroma carried as offset binary
    wire signed [10:0] chroma_sum = comb_c + 11'sd128;
    wire [7:0] chroma_sat = chroma_sum[10] ? 8'h00 :
                            (|chroma_sum[9:8] ? 8'hff : chroma_sum[7:0]);

    // Both channels saturate, so a filter overshoot never wraps
    // around the code range and shows as a bright speck.
    // Killer mode level, held in a flop
    logic killer_r;
    // Result register feeding the buffer
    yc_pair_s res_r;
    // Pipeline fill counter, results are valid once full
    logic [2:0] fill_r;
    wire primed = (fill_r == `YC_PIPE_DEPTH);

    // Killer level registered; it applies to results computed after
    always_ff @(posedge core_clk) begin
        if (!rst_n) killer_r <= 1'b0;
        else killer_r <= color_killer;
    end

    // Bypass keeps the same latency as separation, so switching the
    // killer never shifts the picture sideways.
    // Result select per mode
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            res_r <= '0;
        end else if (adv) begin
            if (killer_r) begin
                res_r.luma <= tc_r[2];
                res_r.chroma <= `YC_CHROMA_ZERO;
            end else begin
                res_r.luma <= luma_sat;
                res_r.chroma <= chroma_sat;
            end
        end
    end

    // Five advances fill the taps; earlier results would mix in
    // samples from before reset and are never pushed.
    // Count advances until the taps hold real samples
    always_ff @(posedge core_clk) begin
        if (!rst_n) fill_r <= 3'h0;
        else if (adv && !primed) fill_r <= fill_r + 3'h1;
    end

    // After a primed advance the stall below keeps res_r unchanged
    // Result valid flag, pushed one cycle after its advance
    logic res_vld_r;
    always_ff @(posedge core_clk) begin
        if (!rst_n) res_vld_r <= 1'b0;
        else res_vld_r <= adv & primed;
    end

    // Trade-off: the stall halves the peak rate, but it lets a
    // two-entry buffer absorb a full stop of the sink with no loss.
    // Buffer has a free slot for the next push
    logic buf_in_ready;
    // Stall in the cycle of each push so a pending word always fits
    assign buf_ready = buf_in_ready & ~res_vld_r;
    assign sample_ready = buf_ready;

    // The buffer stores whole pairs, so luma and chroma leave
    // together from flops and stand until the sink takes them.
    // Two 8-bit channels leave through the buffer
    yc_out_buf #(
        .W($bits(yc_pair_s)),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(res_vld_r),
        .in_ready(buf_in_ready),
        .in_data(res_r),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(yc_out)
    );

endmodule // two_line_yc_separator
`default_nettype wire

// ### two_line_yc_separator_monitor.sv
// Port checker for the two-line separator
`timescale 1ns/10ps
`default_nettype none
`include "yc_sep_map.svh"
module two_line_yc_separator_monitor #(
    parameter int LINE_LEN = 910,
    parameter int BUF_DEPTH = 2
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] composite_video_in,
    input wire logic sample_valid,
    input wire logic sample_ready,
    input wire logic subcarrier_reference_in,
    input wire logic color_killer,
    input wire logic ref_locked,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire yc_sep_pkg::yc_pair_s yc_out
);
    import yc_sep_pkg::*;
    logic acc; // Sample taken at this edge
    logic rise; // Reference rising edge
    logic ref_q_r; // Reference one cycle back
    logic [3:0] gap_r, good_r, prime_r, kill_r; // Saturating helper counts
    assign acc = sample_valid && sample_ready;
    assign rise = subcarrier_reference_in && !ref_q_r;
    // Period length, good periods in a row, accepts since reset
    // Reset counts as a fresh reference edge; the level before it is forgotten
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ref_q_r <= 1'b0;
            gap_r <= 4'h1;
            good_r <= 4'h0;
            prime_r <= 4'h0;
        end else begin
            ref_q_r <= subcarrier_reference_in;
            if (rise) gap_r <= 4'h1;
            else if (gap_r != 4'hf) gap_r <= gap_r + 4'h1;
            if (rise) good_r <= (gap_r == 4'h4) ? good_r + {3'h0, good_r != 4'hf} : 4'h0;
            if (acc && prime_r != 4'hf) prime_r <= prime_r + 4'h1;
        end
    end
    // Accepts under killer; four flush older words out of the buffer
    always_ff @(posedge core_clk) begin
        if (!rst_n || !color_killer) kill_r <= 4'h0;
        else if (acc && kill_r != 4'hf) kill_r <= kill_r + 4'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        sample_valid && sample_ready;
    endsequence
    sequence s_primed_take;
        s_take ##0 (prime_r >= 4'h5);
    endsequence
    // Priming accepts push nothing, so those may come back to back
    property p_stall; s_primed_take |=> !sample_ready; endproperty
    property p_push; s_primed_take |-> ##2 out_valid; endproperty
    property p_rise; $rose(out_valid) |-> $past(acc, 2); endproperty
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(yc_out); endproperty
    property p_fell; $fell(out_valid) |-> $past(out_ready); endproperty
    property p_reset;
        disable iff (1'b0) !rst_n |=> !out_valid && !ref_locked && sample_ready;
    endproperty
    property p_lock; $rose(ref_locked) |-> good_r >= 4'h3; endproperty
    property p_lost; ref_locked && rise && gap_r != 4'h4 |-> ##[1:3] !ref_locked; endproperty
    property p_kill; out_valid && kill_r >= 4'h4 |-> yc_out.chroma == `YC_CHROMA_ZERO; endproperty
    a_stall: assert property (p_stall) else $error("sample_ready high after accept");
    a_push: assert property (p_push) else $error("no result two cycles after accept");
    a_rise: assert property (p_rise) else $error("result without accept");
    a_hold: assert property (p_hold) else $error("stalled word changed");
    a_fell: assert property (p_fell) else $error("word dropped untaken");
    a_reset: assert property (p_reset) else $error("bad state after reset");
    a_lock: assert property (p_lock) else $error("lock before three good periods");
    a_lost: assert property (p_lost) else $error("lock kept after bad period");
    a_kill: assert property (p_kill) else $error("chroma not zero in bypass");
endmodule // two_line_yc_separator_monitor
bind two_line_yc_separator two_line_yc_separator_monitor #(
    .LINE_LEN(LINE_LEN), .BUF_DEPTH(BUF_DEPTH)
) mon_inst (
    .core_clk(core_clk), .rst_n(rst_n), .composite_video_in(composite_video_in),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .subcarrier_reference_in(subcarrier_reference_in), .color_killer(color_killer),
    .ref_locked(ref_locked), .out_valid(out_valid), .out_ready(out_ready), .yc_out(yc_out)
);
`default_nettype wire

// ### yc_far_side_model.sv
// Far side: burst-locked reference source and output sink
`timescale 1ns/10ps
`default_nettype none
module yc_far_side_model (
    input wire logic core_clk,
    input wire logic slip,
    input wire logic stall,
    output logic subcarrier_reference_in,
    output logic out_ready
);
    logic [1:0] ph_r = 2'h0; // Phase within one period
    // burst-locked reference
    // Four clocks a period; slip stretches one to five
    always_ff @(posedge core_clk) begin
        if (!slip) ph_r <= ph_r + 2'h1;
    end
    assign subcarrier_reference_in = (ph_r < 2'h2);
    // Sink takes words unless told to stall
    assign out_ready = !stall;
endmodule // yc_far_side_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the two-line separator
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import yc_sep_pkg::*;
    localparam int LINE = 16; // Short line keeps the run brief
    logic core_clk, rst_n, sample_valid, color_killer, slip, stall, stall_en, hold;
    logic sample_ready, subcarrier_reference_in, ref_locked, out_valid, out_ready;
    logic [7:0] composite_video_in;
    logic [31:0] seed;
    yc_pair_s yc_out;
    int bad_count, comparisons, g;
    int off, lmin, v; // Clamp model: offset, line minimum, clamped sample
    int hist[$]; // Accepted samples after clamping, in order
    yc_pair_s exp_q[$]; // Expected words, oldest first
    bit chk_q[$]; // Word predictable once a line is stored
    two_line_yc_separator #(.LINE_LEN(LINE), .BUF_DEPTH(2)) two_line_yc_separator_inst (
        .core_clk(core_clk), .rst_n(rst_n), .composite_video_in(composite_video_in),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .subcarrier_reference_in(subcarrier_reference_in), .color_killer(color_killer),
        .ref_locked(ref_locked), .out_valid(out_valid), .out_ready(out_ready), .yc_out(yc_out));
    yc_far_side_model yc_far_side_model_inst (.core_clk(core_clk), .slip(slip),
        .stall(stall), .subcarrier_reference_in(subcarrier_reference_in),
        .out_ready(out_ready));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Band-pass (-1,0,2,0,-1)/4, rounded down where a clamp step breaks the fit
    function automatic int bp(input int n);
        return (2 * hist[n-2] - hist[n-4] - hist[n]) >>> 2;
    endfunction
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic test_done();
        if (bad_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Expected word for accept n: centre tap minus two-line comb chroma
    task automatic predict(input int n);
        int c, d, k;
        bit m;
        m = n >= LINE + 4;
        c = bp(n);
        d = m ? -bp(n - LINE) : 0;
        k = (c > 0 && d > 0) ? ((c < d) ? c : d) : (c < 0 && d < 0) ? ((c > d) ? c : d) : 0;
        if (color_killer) k = 0;
        exp_q.push_back({8'(hist[n-2] - k), 8'(k + 128)});
        chk_q.push_back(m || color_killer);
    endtask
    // Random stalls by the sink; hold fills the buffer
    always @(posedge core_clk) begin
        seed <= xs(seed);
        stall <= hold || (stall_en && seed[5] && seed[6]);
    end
    // Watch accepts and taken words
    always @(posedge core_clk) begin
        if (rst_n && sample_valid && sample_ready) begin
            v = int'(composite_video_in) + off;
            hist.push_back(v);
            lmin = (v < lmin) ? v : lmin;
            // Line end: offset steps one code toward the tip level
            if (hist.size() % LINE == 0) begin
                off = (lmin > 16) ? off - 1 : (lmin < 16) ? off + 1 : off;
                lmin = 255;
            end
            // The word pushed at this accept uses the taps of the one before
            if (hist.size() > 5) predict(hist.size() - 2);
        end
        if (rst_n && out_valid && out_ready) begin
            if (exp_q.size() == 0) check("extra word", 16'h1, 16'h0);
            else if (chk_q.pop_front()) check("yc_out", yc_out, exp_q.pop_front());
            else void'(exp_q.pop_front());
        end
    end
    // Whole lines, sync tip at each line start; second line is lifted
    task automatic run_lines(input int lines);
        for (int i = 0; i < lines * LINE; i++) begin
            if (seed[20]) begin
                sample_valid <= 1'b0;
                @(posedge core_clk);
            end
            // Four codes high on the second line, so the clamp must step
            composite_video_in <= ((i % LINE == 0) ? 8'h10 : 8'h10 + {seed[3:0], 2'b00})
                + ((i / LINE == 1) ? 8'h04 : 8'h00);
            sample_valid <= 1'b1;
            g = 0;
            do @(posedge core_clk); while (sample_ready !== 1'b1 && g++ < 60);
        end
        sample_valid <= 1'b0;
        repeat (10) @(posedge core_clk);
    endtask
    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        test_done();
    end
    initial begin
        {rst_n, sample_valid, color_killer, slip, stall_en, hold} = 6'h0;
        composite_video_in = 8'h10;
        seed = 32'h5bc67258;
        off = 0;
        lmin = 255;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (40) @(posedge core_clk);
        check("ref_locked", ref_locked, 16'h1);
        slip <= 1'b1;
        @(posedge core_clk);
        slip <= 1'b0;
        g = 0;
        while (ref_locked === 1'b1 && g++ < 10) @(posedge core_clk);
        check("ref_lost", ref_locked, 16'h0);
        repeat (30) @(posedge core_clk);
        check("ref_relock", ref_locked, 16'h1);
        stall_en <= 1'b1;
        hold <= 1'b1;
        fork
            run_lines(4);
            begin
                repeat (20) @(posedge core_clk);
                check("full_ready", {out_valid, sample_ready}, 16'h2);
                hold <= 1'b0;
            end
        join
        color_killer <= 1'b1;
        repeat (4) @(posedge core_clk);
        run_lines(2);
        stall_en <= 1'b0;
        repeat (10) @(posedge core_clk);
        check("left_words", 16'(exp_q.size()), 16'h0);
        test_done();
    end
endmodule // testbench
`default_nettype wire
